// file: rtl/meb_bus_ctrl.sv
// External bus, reset, mode and power control of the microcontroller
`timescale 1ns/1ps
`default_nettype none
module meb_bus_ctrl (
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  input  wire logic [meb_pkg::DATA_W-1:0]    p0_i,
  output var  logic [meb_pkg::DATA_W-1:0]    p0_o,
  output var  logic [meb_pkg::DATA_W-1:0]    p0_oe,
  input  wire logic [meb_pkg::DATA_W-1:0]    p1_i,
  output var  logic [meb_pkg::DATA_W-1:0]    p1_o,
  output var  logic [meb_pkg::DATA_W-1:0]    p1_oe,
  input  wire logic [meb_pkg::DATA_W-1:0]    p2_i,
  output var  logic [meb_pkg::DATA_W-1:0]    p2_o,
  output var  logic [meb_pkg::DATA_W-1:0]    p2_oe,
  input  wire logic [meb_pkg::DATA_W-1:0]    p3_i,
  output var  logic [meb_pkg::DATA_W-1:0]    p3_o,
  output var  logic [meb_pkg::DATA_W-1:0]    p3_oe,
  input  wire logic [meb_pkg::P4_W-1:0]      p4_i,
  output var  logic [meb_pkg::P4_W-1:0]      p4_o,
  output var  logic [meb_pkg::P4_W-1:0]      p4_oe,
  input  wire logic                          addr_latch_i,
  output var  logic                          addr_latch_o,
  output var  logic                          addr_latch_oe,
  input  wire logic                          program_store_strobe_n_i,
  output var  logic                          program_store_strobe_n_o,
  output var  logic                          program_store_strobe_n_oe,
  input  wire logic                          rst_pin,
  input  wire logic                          external_fetch_force_n,
  input  wire logic                          flash_mode_strap,
  input  wire logic                          code_fetch_req,
  input  wire logic                          code_table_read_instruction,
  input  wire logic                          code_is_ext,
  input  wire logic [meb_pkg::ADDR_W-1:0]    code_addr,
  output var  logic                          code_ack,
  output var  logic                          code_done,
  output var  logic [meb_pkg::DATA_W-1:0]    code_data,
  input  wire logic                          xdata_req,
  input  wire logic                          xdata_wr,
  input  wire logic [meb_pkg::ADDR_W-1:0]    xdata_addr,
  input  wire logic [meb_pkg::DATA_W-1:0]    xdata_wdata,
  output var  logic                          xdata_ack,
  output var  logic                          xdata_done,
  output var  logic [meb_pkg::DATA_W-1:0]    xdata_rdata,
  input  wire logic                          port_wr_en,
  input  wire logic [2:0]                    port_wr_sel,
  input  wire logic [meb_pkg::DATA_W-1:0]    port_wr_data,
  input  wire logic [2:0]                    port_rd_sel,
  output var  logic [meb_pkg::DATA_W-1:0]    port_rd_data,
  input  wire logic                          sp_wr_en,
  input  wire logic [meb_pkg::DATA_W-1:0]    sp_wdata,
  output var  logic [meb_pkg::DATA_W-1:0]    stack_ptr,
  input  wire logic                          idle_request_bit,
  input  wire logic                          powerdown_request_bit,
  input  wire logic                          irq_wake,
  input  wire logic [meb_pkg::DATA_W-1:0]    flash_rdata,
  output var  logic [meb_pkg::ADDR_W-1:0]    flash_addr,
  output var  logic [meb_pkg::DATA_W-1:0]    flash_wdata,
  output var  logic                          flash_read,
  output var  logic                          flash_prog,
  output var  logic                          flash_mode,
  output var  logic                          sys_reset,
  output var  logic                          int_clk_phase,
  output var  logic                          cpu_clk_en,
  output var  logic                          periph_clk_en,
  output var  logic                          osc_run,
  output var  logic                          extra_irq_a_n,
  output var  logic                          extra_irq_b_n
);
  import meb_pkg::*;

  localparam int unsigned RCW = $clog2(RST_HOLD_CYC + 1);

  // Synchronised pin inputs
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_s;
  logic [DATA_W-1:0] p0_s;
  logic [DATA_W-1:0] p1_s;
  logic [DATA_W-1:0] p2_s;
  logic [DATA_W-1:0] p3_s;
  logic [P4_W-1:0]   p4_s;
  logic              ale_s;
  logic              pss_s;
  logic              rst_s;
  logic              xff_s;
  logic              strap_s;

  assign sync_raw = {flash_mode_strap, external_fetch_force_n, rst_pin,
                     program_store_strobe_n_i, addr_latch_i, p4_i, p3_i, p2_i, p1_i, p0_i};

  meb_sync #(.W(SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       (sync_raw),
    .q       (sync_s)
  );

  assign {strap_s, xff_s, rst_s, pss_s, ale_s, p4_s, p3_s, p2_s, p1_s, p0_s} = sync_s;

  // State
  logic [RCW-1:0]    rst_cnt_q;
  logic [RCW-1:0]    rst_cnt_d;
  logic              sys_rst_q;
  logic              sys_rst_d;
  logic              flash_q;
  logic              flash_d;
  logic              phase_q;
  logic              idle_q;
  logic              idle_d;
  logic              pwrdn_q;
  logic              pwrdn_d;
  logic [2:0]        sub_q;
  logic [2:0]        sub_d;
  meb_cyc_t          cyc_q;
  meb_cyc_t          cyc_d;
  meb_cyc_t          cyc_nxt;
  meb_cyc_t          prev_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              wr_q;
  logic [DATA_W-1:0] lat_q [NPORT];
  logic [DATA_W-1:0] pin_s [NPORT];
  logic [DATA_W-1:0] sp_q;

  // Reset recognition
  logic rst_hit;
  assign rst_hit   = rst_cnt_q == RCW'(RST_HOLD_CYC);
  assign rst_cnt_d = !rst_s ? '0 : (rst_hit ? rst_cnt_q : rst_cnt_q + RCW'(1));
  assign sys_rst_d = rst_s & rst_hit & ~flash_q;

  // Mode follows the strap while in device reset or in flash mode
  assign flash_d = (sys_rst_q | flash_q) ? strap_s : flash_q;

  // Power management, idle request wins over wake; wake does not end power-down, only device reset does
  assign idle_d  = ~sys_rst_q & (idle_request_bit | (idle_q & ~irq_wake));
  assign pwrdn_d = ~sys_rst_q & (powerdown_request_bit | pwrdn_q);

  // Bus slot sequencing
  logic run;
  logic slot_end;
  logic fetch_any;
  logic fetch_ext;
  logic take_x;
  logic take_f;
  assign run       = ~flash_q & ~sys_rst_q & ~pwrdn_q;
  assign slot_end  = sub_q == SLOT_LAST;
  assign sub_d     = (slot_end | ~run) ? 3'h0 : sub_q + 3'h1;
  assign fetch_any = code_fetch_req | code_table_read_instruction;
  assign fetch_ext = ~xff_s | code_is_ext;
  assign take_x    = slot_end & run & (cyc_q != CY_XADDR) & xdata_req;
  assign take_f    = slot_end & run & (cyc_q != CY_XADDR) & ~xdata_req & fetch_any & fetch_ext;
  assign code_ack  = take_f;
  assign xdata_ack = take_x;

  always_comb begin
    cyc_nxt = CY_NONE;
    unique case (cyc_q)
      CY_XADDR:                    cyc_nxt = CY_XSTRB;
      CY_NONE, CY_FETCH, CY_XSTRB: cyc_nxt = take_x ? CY_XADDR : (take_f ? CY_FETCH : CY_NONE);
      default:                     cyc_nxt = CY_NONE;
    endcase
  end

  assign cyc_d = !run ? CY_NONE : (slot_end ? cyc_nxt : cyc_q);

  // Pin phase decode
  logic ext_bus;
  logic x_cyc;
  logic ale_hi;
  logic addr_ph;
  logic strb_x;
  logic program_store_strobe_n_lo;
  logic wdat_ph;
  assign ext_bus = cyc_q != CY_NONE;
  assign x_cyc   = (cyc_q == CY_XADDR) | (cyc_q == CY_XSTRB);
  assign ale_hi  = run & (sub_q <= ALE_HI_LAST) & (cyc_q != CY_XSTRB);
  assign addr_ph = ((cyc_q == CY_FETCH) | (cyc_q == CY_XADDR)) & (sub_q <= ADDR_HOLD_SUB);
  assign strb_x  = ((cyc_q == CY_XADDR) & (sub_q >= STRB_FIRST)) |
                   ((cyc_q == CY_XSTRB) & (sub_q <= STRB_LAST_B));
  assign program_store_strobe_n_lo = (cyc_q == CY_FETCH) & (sub_q >= STRB_FIRST);
  assign wdat_ph = wr_q & (((cyc_q == CY_XADDR) & (sub_q >= STRB_FIRST)) | (cyc_q == CY_XSTRB));

  // Flash mode configuration decode
  logic cfg_ok;
  logic f_read;
  logic f_prog;
  assign cfg_ok = flash_q & rst_s & ~ale_s & pss_s & (p3_s[3:0] == FLASH_CFG_LOW);
  assign f_read = cfg_ok & ~p3_s[OE_BIT];
  assign f_prog = cfg_ok & ~p3_s[CE_BIT] & p3_s[OE_BIT];

  // Next pin values
  logic [DATA_W-1:0] p0_o_d;
  logic [DATA_W-1:0] p0_oe_d;
  logic [DATA_W-1:0] p1_oe_d;
  logic [DATA_W-1:0] p2_o_d;
  logic [DATA_W-1:0] p2_oe_d;
  logic [DATA_W-1:0] p3_o_d;
  logic [DATA_W-1:0] p3_oe_d;
  logic [P4_W-1:0]   p4_oe_d;
  logic              strb_oe_d;

  assign p0_o_d  = flash_q ? flash_rdata : (wdat_ph ? wdata_q : (addr_ph ? addr_q[DATA_W-1:0] : '0));
  assign p0_oe_d = flash_q ? {DATA_W{f_read}} :
                   (ext_bus ? {DATA_W{addr_ph | wdat_ph}} : ~lat_q[P0_IDX]);
  assign p1_oe_d = flash_q ? '0 : ~lat_q[P1_IDX];
  assign p2_o_d  = ext_bus ? addr_q[ADDR_W-1:DATA_W] : '0;
  assign p2_oe_d = flash_q ? '0 : (ext_bus ? '1 : ~lat_q[P2_IDX]);
  assign p4_oe_d = flash_q ? '0 : ~lat_q[P4_IDX][P4_W-1:0];
  assign strb_oe_d = ~flash_q & ~sys_rst_q;

  always_comb begin
    p3_o_d  = '0;
    p3_oe_d = flash_q ? '0 : ~lat_q[P3_IDX];
    if (x_cyc) begin
      p3_o_d[RD_BIT]  = ~(strb_x & ~wr_q);
      p3_o_d[WR_BIT]  = ~(strb_x & wr_q);
      p3_oe_d[RD_BIT] = 1'b1;
      p3_oe_d[WR_BIT] = 1'b1;
    end
  end

  // Port pin readback
  assign pin_s[P0_IDX] = p0_s;
  assign pin_s[P1_IDX] = p1_s;
  assign pin_s[P2_IDX] = p2_s;
  assign pin_s[P3_IDX] = p3_s;
  assign pin_s[P4_IDX] = {{(DATA_W - P4_W){1'b0}}, p4_s};

  // Read capture points
  logic fcap;
  logic xcap;
  assign fcap = (prev_q == CY_FETCH) & (sub_q == FETCH_CAP_SUB);
  assign xcap = (cyc_q == CY_XSTRB) & slot_end;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rst_cnt_q <= '0;
      sys_rst_q <= 1'b0;
      flash_q   <= 1'b0;
      phase_q   <= 1'b0;
      idle_q    <= 1'b0;
      pwrdn_q   <= 1'b0;
      sub_q     <= 3'h0;
      cyc_q     <= CY_NONE;
      prev_q    <= CY_NONE;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      sys_rst_q <= sys_rst_d;
      flash_q   <= flash_d;
      phase_q   <= ~phase_q;
      idle_q    <= idle_d;
      pwrdn_q   <= pwrdn_d;
      sub_q     <= sub_d;
      cyc_q     <= cyc_d;
      prev_q    <= slot_end ? cyc_q : prev_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      addr_q  <= '0;
      wdata_q <= '0;
      wr_q    <= 1'b0;
    end else if (take_x) begin
      addr_q  <= xdata_addr;
      wdata_q <= xdata_wdata;
      wr_q    <= xdata_wr;
    end else if (take_f) begin
      addr_q  <= code_addr;
      wr_q    <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || sys_rst_q) begin
      for (int i = 0; i < NPORT; i++) begin
        lat_q[i] <= PORT_RST;
      end
      sp_q <= SP_RST;
    end else begin
      if (port_wr_en && (port_wr_sel < 3'(NPORT))) begin
        lat_q[port_wr_sel] <= port_wr_data;
      end
      if (sp_wr_en) begin
        sp_q <= sp_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      code_done    <= 1'b0;
      code_data    <= '0;
      xdata_done   <= 1'b0;
      xdata_rdata  <= '0;
      port_rd_data <= '0;
    end else begin
      code_done    <= fcap;
      code_data    <= fcap ? p0_s : code_data;
      xdata_done   <= xcap;
      xdata_rdata  <= (xcap && !wr_q) ? p0_s : xdata_rdata;
      port_rd_data <= (port_rd_sel < 3'(NPORT)) ? pin_s[port_rd_sel] : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      p0_o                      <= '0;
      p0_oe                     <= '0;
      p1_oe                     <= '0;
      p2_o                      <= '0;
      p2_oe                     <= '0;
      p3_o                      <= '0;
      p3_oe                     <= '0;
      p4_oe                     <= '0;
      addr_latch_o              <= 1'b0;
      addr_latch_oe             <= 1'b0;
      program_store_strobe_n_o  <= 1'b1;
      program_store_strobe_n_oe <= 1'b0;
    end else begin
      p0_o                      <= p0_o_d;
      p0_oe                     <= p0_oe_d;
      p1_oe                     <= p1_oe_d;
      p2_o                      <= p2_o_d;
      p2_oe                     <= p2_oe_d;
      p3_o                      <= p3_o_d;
      p3_oe                     <= p3_oe_d;
      p4_oe                     <= p4_oe_d;
      addr_latch_o              <= ale_hi;
      addr_latch_oe             <= strb_oe_d;
      program_store_strobe_n_o  <= ~program_store_strobe_n_lo;
      program_store_strobe_n_oe <= strb_oe_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flash_addr    <= '0;
      flash_wdata   <= '0;
      flash_read    <= 1'b0;
      flash_prog    <= 1'b0;
      extra_irq_a_n <= 1'b1;
      extra_irq_b_n <= 1'b1;
    end else begin
      flash_addr    <= flash_q ? {p2_s, p1_s} : '0;
      flash_wdata   <= flash_q ? p0_s : '0;
      flash_read    <= f_read;
      flash_prog    <= f_prog;
      extra_irq_a_n <= flash_q | p4_s[IRQA_BIT];
      extra_irq_b_n <= flash_q | p4_s[IRQB_BIT];
    end
  end

  assign p1_o          = '0;
  assign p4_o          = '0;
  assign stack_ptr     = sp_q;
  assign flash_mode    = flash_q;
  assign sys_reset     = sys_rst_q;
  assign int_clk_phase = phase_q;
  assign cpu_clk_en    = phase_q & ~idle_q & ~pwrdn_q;
  assign periph_clk_en = phase_q & ~pwrdn_q;
  assign osc_run       = ~pwrdn_q;

endmodule : meb_bus_ctrl
`default_nettype wire

// file: rtl/meb_pkg.sv
// Constants and types for the external bus and mode controller
package meb_pkg;

  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned P4_W          = 4;
  localparam int unsigned NPORT         = 5;
  localparam int unsigned SYNC_W        = 4 * DATA_W + P4_W + 5;

  localparam int unsigned OSC_PER_STATE = 2;
  localparam int unsigned STATES_PER_MC = 6;
  localparam int unsigned MC_OSC        = OSC_PER_STATE * STATES_PER_MC;
  localparam int unsigned RST_HOLD_MC   = 2;
  localparam int unsigned RST_HOLD_CYC  = RST_HOLD_MC * MC_OSC;

  localparam logic [2:0] SLOT_LAST      = 3'h5;
  localparam logic [2:0] ALE_HI_LAST    = 3'h1;
  localparam logic [2:0] ADDR_HOLD_SUB  = 3'h2;
  localparam logic [2:0] STRB_FIRST     = 3'h3;
  localparam logic [2:0] STRB_LAST_B    = 3'h4;
  localparam logic [2:0] FETCH_CAP_SUB  = 3'h1;

  localparam logic [7:0] PORT_RST       = 8'hff;
  localparam logic [7:0] SP_RST         = 8'h07;

  localparam logic [2:0] P0_IDX         = 3'h0;
  localparam logic [2:0] P1_IDX         = 3'h1;
  localparam logic [2:0] P2_IDX         = 3'h2;
  localparam logic [2:0] P3_IDX         = 3'h3;
  localparam logic [2:0] P4_IDX         = 3'h4;

  localparam int unsigned RD_BIT        = 7;
  localparam int unsigned WR_BIT        = 6;
  localparam int unsigned CE_BIT        = 6;
  localparam int unsigned OE_BIT        = 7;
  localparam int unsigned IRQA_BIT      = 2;
  localparam int unsigned IRQB_BIT      = 3;
  localparam logic [3:0] FLASH_CFG_LOW  = 4'h0;

  typedef enum logic [3:0] {
    CY_NONE  = 4'h1,
    CY_FETCH = 4'h2,
    CY_XADDR = 4'h4,
    CY_XSTRB = 4'h8
  } meb_cyc_t;

endpackage : meb_pkg

// file: rtl/meb_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module meb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      // Idle high like the pulled-up pins, so no false low follows reset
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : meb_sync
`default_nettype wire

// file: testbench/meb_chk.sv
// Pin timing checker for the external bus controller
`timescale 1ns/1ps
`default_nettype none
module meb_chk (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p2_oe,
  input wire logic       addr_latch_o,
  input wire logic       addr_latch_oe,
  input wire logic       program_store_strobe_n_o,
  input wire logic       program_store_strobe_n_oe,
  input wire logic       code_ack,
  input wire logic       code_done,
  input wire logic       xdata_ack,
  input wire logic       xdata_done,
  input wire logic       sys_reset,
  input wire logic       flash_mode,
  input wire logic       int_clk_phase,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_run,
  input wire logic       extra_irq_a_n,
  input wire logic       extra_irq_b_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  strobe_float_a:
    assert property (sys_reset && $past(sys_reset) |-> !addr_latch_oe
      && !program_store_strobe_n_oe) else $error("strobe driven in reset");
  ale_rate_a:
    assert property (disable iff (!nrst || sys_reset || !osc_run)
      $rose(addr_latch_o) |=> addr_latch_o ##1 !addr_latch_o [*4])
      else $error("latch strobe period wrong");
  fetch_done_a:
    assert property (disable iff (!nrst || sys_reset) code_ack |-> ##9 code_done)
      else $error("fetch done late");
  fetch_walk_a:
    assert property (code_ack |-> ##2 (addr_latch_o && p0_oe == 8'hff && p2_oe == 8'hff)
      ##2 (!addr_latch_o && p0_oe == 8'hff) ##1 (p0_oe == 8'h00 && !program_store_strobe_n_o))
      else $error("fetch address phase wrong");
  p0_float_a:
    assert property (program_store_strobe_n_oe && !program_store_strobe_n_o |-> p0_oe == 8'h00)
      else $error("port 0 driven under strobe");
  xdata_skip_a:
    assert property (xdata_ack |-> ##8 !addr_latch_o ##1 !addr_latch_o ##4 xdata_done)
      else $error("latch pulse not skipped");
  idle_clk_a:
    assert property (cpu_clk_en |-> periph_clk_en && int_clk_phase)
      else $error("core clock without peripheral clock");
  pwrdn_clk_a:
    assert property (!osc_run |-> !cpu_clk_en && !periph_clk_en)
      else $error("clock runs in power-down");
  pwrdn_hold_a:
    assert property (!osc_run && !sys_reset ##1 !sys_reset |-> !osc_run)
      else $error("power-down left without reset");
  flash_irq_a:
    assert property (flash_mode && $past(flash_mode) |-> extra_irq_a_n && extra_irq_b_n)
      else $error("extra interrupt active in flash mode");
endmodule : meb_chk
bind meb_bus_ctrl meb_chk i_meb_chk (.ref_clk, .nrst, .p0_oe, .p2_oe, .addr_latch_o,
  .addr_latch_oe, .program_store_strobe_n_o, .program_store_strobe_n_oe, .code_ack,
  .code_done, .xdata_ack, .xdata_done, .sys_reset, .flash_mode, .int_clk_phase,
  .cpu_clk_en, .periph_clk_en, .osc_run, .extra_irq_a_n, .extra_irq_b_n);
`default_nettype wire

// file: testbench/meb_mem_model.sv
// External code and data memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module meb_mem_model (
  input  wire logic       ref_clk,
  input  wire logic       en,
  input  wire logic [7:0] p0_pin,
  input  wire logic [7:0] p2_pin,
  input  wire logic [7:0] p3_pin,
  input  wire logic       ale_pin,
  input  wire logic       str_pin,
  output var  logic       drv,
  output var  logic [7:0] val
);
  logic [15:0] addr_q;
  logic [7:0]  ram [0:255];
  always_ff @(posedge ref_clk) begin
    if (en && ale_pin)
      addr_q <= {p2_pin, p0_pin};
    if (en && !p3_pin[6])
      ram[addr_q[7:0]] <= p0_pin;
  end
  assign drv = en && (!str_pin || !p3_pin[7]);
  assign val = !str_pin ? (addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a) : ram[addr_q[7:0]];
endmodule : meb_mem_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the external bus and mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import meb_pkg::*;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
  logic ref_clk, nrst, rst_pin, external_fetch_force_n, flash_mode_strap, code_is_ext;
  logic code_fetch_req, code_table_read_instruction, xdata_req, xdata_wr, irq_wake;
  logic port_wr_en, sp_wr_en, idle_request_bit, powerdown_request_bit;
  logic tb_ale, tb_str, fl_drv, m_drv, ale_pin, str_pin;
  logic [15:0] code_addr, xdata_addr, flash_addr, a;
  logic [7:0] xdata_wdata, port_wr_data, sp_wdata, flash_rdata, fl_p0, m_val, d;
  logic [7:0] tb_p1, tb_p2, tb_p3, p0_pin, p1_pin, p2_pin, p3_pin;
  logic [7:0] p0_o, p0_oe, p1_o, p1_oe, p2_o, p2_oe, p3_o, p3_oe, code_data;
  logic [7:0] xdata_rdata, port_rd_data, stack_ptr, flash_wdata;
  logic [7:0] p0_last = 8'h00;
  logic [3:0] tb_p4, p4_pin, p4_o, p4_oe;
  logic [2:0] port_wr_sel, port_rd_sel;
  logic addr_latch_o, addr_latch_oe, program_store_strobe_n_o, program_store_strobe_n_oe;
  logic code_ack, code_done, xdata_ack, xdata_done, flash_read, flash_prog, flash_mode;
  logic sys_reset, int_clk_phase, cpu_clk_en, periph_clk_en, osc_run;
  logic extra_irq_a_n, extra_irq_b_n;
  logic [15:0] xa [8];
  logic [7:0]  xd [8];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed, i;
  integer n, m;
  meb_bus_ctrl i_meb_bus_ctrl (.ref_clk, .nrst, .p0_i(p0_pin), .p0_o, .p0_oe,
    .p1_i(p1_pin), .p1_o, .p1_oe, .p2_i(p2_pin), .p2_o, .p2_oe, .p3_i(p3_pin), .p3_o,
    .p3_oe, .p4_i(p4_pin), .p4_o, .p4_oe, .addr_latch_i(ale_pin), .addr_latch_o,
    .addr_latch_oe, .program_store_strobe_n_i(str_pin), .program_store_strobe_n_o,
    .program_store_strobe_n_oe, .rst_pin, .external_fetch_force_n, .flash_mode_strap,
    .code_fetch_req, .code_table_read_instruction, .code_is_ext, .code_addr, .code_ack,
    .code_done, .code_data, .xdata_req, .xdata_wr, .xdata_addr, .xdata_wdata, .xdata_ack,
    .xdata_done, .xdata_rdata, .port_wr_en, .port_wr_sel, .port_wr_data, .port_rd_sel,
    .port_rd_data, .sp_wr_en, .sp_wdata, .stack_ptr, .idle_request_bit,
    .powerdown_request_bit, .irq_wake, .flash_rdata, .flash_addr, .flash_wdata,
    .flash_read, .flash_prog, .flash_mode, .sys_reset, .int_clk_phase, .cpu_clk_en,
    .periph_clk_en, .osc_run, .extra_irq_a_n, .extra_irq_b_n);
  meb_mem_model i_meb_mem_model (.ref_clk, .en(!flash_mode_strap), .p0_pin, .p2_pin,
    .p3_pin, .ale_pin, .str_pin, .drv(m_drv), .val(m_val));
  // Pin levels: released port 0 shows a changing pattern, other pins pull up
  assign p0_pin = (p0_oe & p0_o) | (~p0_oe & (m_drv ? m_val : fl_drv ? fl_p0 : ~p0_last));
  assign p1_pin = (p1_oe & p1_o) | (~p1_oe & tb_p1);
  assign p2_pin = (p2_oe & p2_o) | (~p2_oe & tb_p2);
  assign p3_pin = (p3_oe & p3_o) | (~p3_oe & tb_p3);
  assign p4_pin = (p4_oe & p4_o) | (~p4_oe & tb_p4);
  assign ale_pin = addr_latch_oe ? addr_latch_o : tb_ale;
  assign str_pin = program_store_strobe_n_oe ? program_store_strobe_n_o : tb_str;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    p0_last <= $isunknown(p0_pin) ? 8'h00 : p0_pin;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      complete_run();
    end
  end
  function automatic logic [7:0] code_exp(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5a;
  endfunction : code_exp
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  task automatic test_end(input string s);
    $display("Test %s done, errors so far %0d", s, err_count);
  endtask : test_end
  task automatic fetch(input logic [15:0] ad, input logic tbl, input logic ok);
    code_addr <= ad;
    code_fetch_req <= !tbl;
    code_table_read_instruction <= tbl;
    for (int k = 0; k < 14 && !code_ack; k++) @(posedge ref_clk);
    `CHK(code_ack, ok)
    code_fetch_req <= 1'b0;
    code_table_read_instruction <= 1'b0;
    if (ok) begin
      for (int k = 0; k < 12 && !code_done; k++) @(posedge ref_clk);
      `CHK(code_data, code_exp(ad))
    end
  endtask : fetch
  task automatic xdat(input logic wr, input logic [15:0] ad, input logic [7:0] dv);
    xdata_req <= 1'b1;
    xdata_wr <= wr;
    xdata_addr <= ad;
    xdata_wdata <= dv;
    for (int k = 0; k < 14 && !xdata_ack; k++) @(posedge ref_clk);
    xdata_req <= 1'b0;
    for (int k = 0; k < 16 && !xdata_done; k++) @(posedge ref_clk);
    `CHK(xdata_done, 1'b1)
    if (!wr) `CHK(xdata_rdata, dv)
  endtask : xdat
  task automatic count_en(output integer c, output integer p);
    c = 0;
    p = 0;
    repeat (12) begin
      @(posedge ref_clk);
      c += cpu_clk_en;
      p += periph_clk_en;
    end
  endtask : count_en
  task automatic dev_reset(input int k);
    rst_pin <= 1'b1;
    tick(k);
    rst_pin <= 1'b0;
  endtask : dev_reset
  task automatic complete_run();
    $display("Counts: comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    seed = 32'h3865;
    {nrst, rst_pin, flash_mode_strap, code_fetch_req, code_table_read_instruction} = '0;
    {xdata_req, xdata_wr, port_wr_en, sp_wr_en, idle_request_bit} = '0;
    {powerdown_request_bit, irq_wake, fl_drv, code_addr, xdata_addr} = '0;
    {xdata_wdata, port_wr_data, sp_wdata, flash_rdata, fl_p0, port_wr_sel} = '0;
    {external_fetch_force_n, code_is_ext, tb_ale, tb_str} = 4'hf;
    {tb_p1, tb_p2, tb_p3, tb_p4} = 28'hfffffff;
    port_rd_sel = P1_IDX;
    tick(10);
    nrst <= 1'b1;
    tick(4);
    `CHK(stack_ptr, SP_RST)
    `CHK(p1_oe, ~PORT_RST)
    d = 8'($random(seed));
    port_wr_en <= 1'b1;
    port_wr_sel <= P1_IDX;
    port_wr_data <= d;
    tick(1);
    port_wr_sel <= P4_IDX;
    port_wr_data <= 8'h0b;
    sp_wdata <= d;
    sp_wr_en <= 1'b1;
    tick(1);
    {port_wr_en, sp_wr_en} <= 2'b00;
    tick(5);
    `CHK(p1_oe, ~d)
    `CHK(port_rd_data, d)
    `CHK({extra_irq_b_n, extra_irq_a_n}, 2'b10)
    test_end("ports");
    dev_reset(12);
    count_en(n, m);
    `CHK(n, 6)
    `CHK(sys_reset, 1'b0)
    dev_reset(30);
    `CHK(sys_reset, 1'b1)
    `CHK({addr_latch_oe, program_store_strobe_n_oe}, 2'b00)
    `CHK(stack_ptr, SP_RST)
    `CHK(p1_oe, 8'h00)
    tick(4);
    test_end("device reset");
    for (i = 0; i < 16; i++) begin
      a = 16'($random(seed));
      fetch(a, i[0], 1'b1);
    end
    code_is_ext <= 1'b0;
    external_fetch_force_n <= 1'b0;
    tick(4);
    fetch(16'h1234, 1'b0, 1'b1);
    external_fetch_force_n <= 1'b1;
    tick(4);
    fetch(16'h0042, 1'b0, 1'b0);
    code_is_ext <= 1'b1;
    test_end("code fetch");
    for (i = 0; i < 8; i++) begin
      xa[i] = {8'($random(seed)), 8'(i * 37)};
      xd[i] = 8'($random(seed));
      xdat(1'b1, xa[i], xd[i]);
    end
    for (i = 0; i < 8; i++)
      xdat(1'b0, xa[i], xd[i]);
    test_end("data access");
    idle_request_bit <= 1'b1;
    tick(1);
    idle_request_bit <= 1'b0;
    tick(3);
    count_en(n, m);
    `CHK(n, 0)
    `CHK(m, 6)
    irq_wake <= 1'b1;
    tick(1);
    irq_wake <= 1'b0;
    tick(3);
    count_en(n, m);
    `CHK(n, 6)
    powerdown_request_bit <= 1'b1;
    tick(1);
    powerdown_request_bit <= 1'b0;
    tick(3);
    count_en(n, m);
    `CHK({osc_run, m}, {1'b0, 32'd0})
    irq_wake <= 1'b1;
    tick(1);
    irq_wake <= 1'b0;
    tick(4);
    `CHK(osc_run, 1'b0)
    dev_reset(30);
    tick(4);
    `CHK(osc_run, 1'b1)
    test_end("power");
    flash_mode_strap <= 1'b1;
    rst_pin <= 1'b1;
    tick(30);
    {tb_ale, tb_str, tb_p3, tb_p4} <= {2'b01, 8'h40, 4'h0};
    {tb_p2, tb_p1, flash_rdata} <= 24'($random(seed));
    tick(8);
    `CHK({flash_mode, flash_read, addr_latch_oe}, 3'b110)
    `CHK(flash_addr, {tb_p2, tb_p1})
    `CHK({p0_oe, p0_o}, {8'hff, flash_rdata})
    `CHK({extra_irq_b_n, extra_irq_a_n}, 2'b11)
    d = 8'($random(seed));
    {tb_p3, fl_drv, fl_p0} <= {8'h80, 1'b1, d};
    tick(8);
    `CHK({flash_prog, flash_read, flash_wdata}, {2'b10, d})
    tb_ale <= 1'b1;
    tick(8);
    `CHK(flash_prog, 1'b0)
    {flash_mode_strap, rst_pin, fl_drv, tb_p3, tb_p4} <= {3'b000, 8'hff, 4'hf};
    tick(8);
    `CHK(flash_mode, 1'b0)
    fetch(16'hbeef, 1'b0, 1'b1);
    test_end("flash mode");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
